// ### core/sfc_regs.svh
// Register offsets, field positions, reset values and clearing masks of the fault clear manager
//
// Notes on behaviour
// - Common alarms: cleared by alarm reset or restart
// - Undervoltage clears itself when voltage recovers
// - Motor and encoder faults clear only on restart
// - Reserved codes are never cleared once set
// - Adjustment fault: connector removed, then autotune done
// - Emergency stop fault clears when input released
// - Limit faults: alarm reset or servo off
// - Encoder output, protection faults: alarm reset only
// - Serial fault: alarm reset or link normal
// - Phase loss: alarm reset or phase restored
// - Motor temperature warning clears at normal temperature
// - Firmware alarm: write 30, 28, then restart
// - Six most recent fault codes kept in history
`ifndef SFC_REGS_SVH
`define SFC_REGS_SVH

// ----------------------------------------------------------------
// Fault code bit positions
// ----------------------------------------------------------------
`define SFC_NUM_FAULTS    33
`define SFC_BIT_UNDERVOLT 2
`define SFC_BIT_ADJUST    11
`define SFC_BIT_ESTOP     12
`define SFC_BIT_SERIAL    18
`define SFC_BIT_PHASE     21
`define SFC_BIT_MTEMP_W   31
`define SFC_BIT_FW_UPG    32

// ----------------------------------------------------------------
// Clearing class masks
// ----------------------------------------------------------------
`define SFC_ALARM_RESET_INPUT_MASK     33'h0_486f_e1f3
`define SFC_RESTART_MASK  33'h0_37c9_85fb
`define SFC_SERVOFF_MASK  33'h0_0000_6000
`define SFC_RSVD_MASK     33'h0_0010_0200

// ----------------------------------------------------------------
// Firmware clear sequence values
// ----------------------------------------------------------------
`define SFC_FW_KEY1       16'h001e
`define SFC_FW_KEY2       16'h001c

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define SFC_ADDR_W        8
`define SFC_OFS_FAULT_LO  8'h00
`define SFC_OFS_FAULT_HI  8'h04
`define SFC_OFS_SPF       8'h08
`define SFC_OFS_IRQ_STAT  8'h0c
`define SFC_OFS_IRQ_CLR   8'h10
`define SFC_OFS_IRQ_EN    8'h14
`define SFC_OFS_FW_STATE  8'h18
`define SFC_OFS_HIST_CNT  8'h1c
`define SFC_OFS_HIST0     8'h20
`define SFC_OFS_HIST5     8'h34

// ----------------------------------------------------------------
// Field widths, positions and reset values
// ----------------------------------------------------------------
`define SFC_HIST_DEPTH    6
`define SFC_CODE_W        8
`define SFC_IRQ_W         2
`define SFC_IRQ_SET_BIT   0
`define SFC_IRQ_CLR_BIT   1
`define SFC_SPF_RST       16'h0000
`define SFC_IRQ_EN_RST    2'h0
`define SFC_PIN_RST       3'h4

`endif

// ### core/sfc_pkg.sv
// Types shared by the fault clear manager files
package sfc_pkg;

  // ----------------------------------------------------------------
  // Register port request
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } sfc_bus_req_t;

  // ----------------------------------------------------------------
  // Recovery conditions reported by monitors on the same clock
  // ----------------------------------------------------------------
  typedef struct packed {
    logic voltage_ok;
    logic comm_ok;
    logic phase_ok;
    logic temp_ok;
    logic servo_off;
    logic autotune_done;
  } sfc_recov_t;

  // ----------------------------------------------------------------
  // Firmware alarm clear sequence
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FW_IDLE,
    FW_GOT_KEY1,
    FW_ARMED
  } sfc_fw_state_t;

endpackage

// ### core/sfc_hist_mem.sv
// Small fault history memory with registered read data
`timescale 1ns/100ps
module sfc_hist_mem (
  input  wire logic       sys_clk_i,
  input  wire logic       we_i,
  input  wire logic [2:0] waddr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic [2:0] raddr_i,
  output logic      [7:0] rdata_o
);

  logic [7:0] mem_q [0:5];

  // ----------------------------------------------------------------
  // Write and registered read
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (we_i)
    begin
      mem_q[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    rdata_o <= mem_q[raddr_i];
  end

endmodule // sfc_hist_mem

// ### core/sfc_fault_mgr.sv
// Fault latch and clear manager with fault history and register port
//
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/100ps
`include "sfc_regs.svh"
module sfc_fault_mgr (
  input  wire logic                      sys_clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      restart_i,
  input  wire logic [32:0]               fault_det_i,
  input  wire sfc_pkg::sfc_recov_t       recov_i,
  input  wire logic                      alarm_reset_input_i,
  input  wire logic                      emergency_stop_input_i,
  input  wire logic                      io_signal_connector_present_i,
  input  wire sfc_pkg::sfc_bus_req_t     bus_req_i,
  output logic      [31:0]               bus_rdata_o,
  output logic      [32:0]               fault_vec_o,
  output logic                           fault_any_o,
  output logic                           irq_o
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Lowest set bit, returned as code (index + 1), zero if none
  function automatic logic [7:0] first_code(input logic [32:0] v);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 32; i >= 0; i--)
    begin
      if (v[i])
      begin
        c = 8'(i + 1);
      end
    end
    return c;
  endfunction

  // Slot of the k-th most recent entry in the ring
  function automatic logic [2:0] hist_slot(input logic [2:0] wp, input logic [2:0] k);
    logic [3:0] s;
    s = 4'(wp) + 4'd5 - 4'(k);
    if (s >= 4'd6)
    begin
      s = s - 4'd6;
    end
    return s[2:0];
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] pin_meta_q;
  logic [2:0] pin_sync_q;
  logic       alarm_reset_input_s;
  logic       estop_s;
  logic       conn_s;

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      pin_meta_q <= `SFC_PIN_RST;
      pin_sync_q <= `SFC_PIN_RST;
    end
    else
    begin
      pin_meta_q <= {io_signal_connector_present_i, emergency_stop_input_i, alarm_reset_input_i};
      pin_sync_q <= pin_meta_q;
    end
  end

  assign alarm_reset_input_s  = pin_sync_q[0];
  assign estop_s = pin_sync_q[1];
  assign conn_s  = pin_sync_q[2];

  // ----------------------------------------------------------------
  // Register port decode
  // ----------------------------------------------------------------
  logic wr_spf;
  logic wr_irq_clr;
  logic wr_irq_en;

  assign wr_spf     = bus_req_i.wr && (bus_req_i.addr == `SFC_OFS_SPF);
  assign wr_irq_clr = bus_req_i.wr && (bus_req_i.addr == `SFC_OFS_IRQ_CLR);
  assign wr_irq_en  = bus_req_i.wr && (bus_req_i.addr == `SFC_OFS_IRQ_EN);

  // ----------------------------------------------------------------
  // Special function parameter
  // ----------------------------------------------------------------
  logic [15:0] spf_q;

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      spf_q <= `SFC_SPF_RST;
    end
    else if (wr_spf)
    begin
      spf_q <= bus_req_i.wdata[15:0];
    end
  end

  // ----------------------------------------------------------------
  // Firmware alarm clear sequence
  // ----------------------------------------------------------------
  sfc_pkg::sfc_fw_state_t fw_state_q;
  logic                   fw_clear;

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      fw_state_q <= sfc_pkg::FW_IDLE;
    end
    else if (restart_i)
    begin
      fw_state_q <= sfc_pkg::FW_IDLE;
    end
    else if (wr_spf)
    begin
      case (fw_state_q)
        sfc_pkg::FW_IDLE:
        begin
          if (bus_req_i.wdata[15:0] == `SFC_FW_KEY1)
          begin
            fw_state_q <= sfc_pkg::FW_GOT_KEY1;
          end
        end
        sfc_pkg::FW_GOT_KEY1:
        begin
          if (bus_req_i.wdata[15:0] == `SFC_FW_KEY2)
          begin
            fw_state_q <= sfc_pkg::FW_ARMED;
          end
          else if (bus_req_i.wdata[15:0] != `SFC_FW_KEY1)
          begin
            fw_state_q <= sfc_pkg::FW_IDLE;
          end
        end
        sfc_pkg::FW_ARMED:
        begin
          if (bus_req_i.wdata[15:0] == `SFC_FW_KEY1)
          begin
            fw_state_q <= sfc_pkg::FW_GOT_KEY1;
          end
          else
          begin
            fw_state_q <= sfc_pkg::FW_IDLE;
          end
        end
        default:
        begin
          fw_state_q <= sfc_pkg::FW_IDLE;
        end
      endcase
    end
  end

  assign fw_clear = restart_i && (fw_state_q == sfc_pkg::FW_ARMED);

  // ----------------------------------------------------------------
  // Adjustment fault clear sequence
  // ----------------------------------------------------------------
  logic adj_unplugged_q;
  logic adj_clear;

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      adj_unplugged_q <= 1'b0;
    end
    else if (!fault_vec_o[`SFC_BIT_ADJUST] || adj_clear)
    begin
      adj_unplugged_q <= 1'b0;
    end
    else if (!conn_s)
    begin
      adj_unplugged_q <= 1'b1;
    end
  end

  assign adj_clear = adj_unplugged_q && recov_i.autotune_done;

  // ----------------------------------------------------------------
  // Fault latches
  // ----------------------------------------------------------------
  logic [32:0] set_vec;
  logic [32:0] auto_clr;
  logic [32:0] clr_vec;
  logic [32:0] fault_d;

  always_comb
  begin
    set_vec = fault_det_i;
    set_vec[`SFC_BIT_ESTOP] = fault_det_i[`SFC_BIT_ESTOP] | estop_s;
    auto_clr = 33'h0_0000_0000;
    auto_clr[`SFC_BIT_UNDERVOLT] = recov_i.voltage_ok;
    auto_clr[`SFC_BIT_ESTOP]     = !estop_s;
    auto_clr[`SFC_BIT_SERIAL]    = recov_i.comm_ok;
    auto_clr[`SFC_BIT_PHASE]     = recov_i.phase_ok;
    auto_clr[`SFC_BIT_MTEMP_W]   = recov_i.temp_ok;
    auto_clr[`SFC_BIT_ADJUST]    = adj_clear;
    auto_clr[`SFC_BIT_FW_UPG]    = fw_clear;
    clr_vec = auto_clr;
    if (alarm_reset_input_s)
    begin
      clr_vec = clr_vec | `SFC_ALARM_RESET_INPUT_MASK;
    end
    if (restart_i)
    begin
      clr_vec = clr_vec | `SFC_RESTART_MASK;
    end
    if (recov_i.servo_off)
    begin
      clr_vec = clr_vec | `SFC_SERVOFF_MASK;
    end
    clr_vec = clr_vec & ~`SFC_RSVD_MASK;
    fault_d = set_vec | (fault_vec_o & ~clr_vec);
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      fault_vec_o <= 33'h0_0000_0000;
    end
    else
    begin
      fault_vec_o <= fault_d;
    end
  end

  assign fault_any_o = |fault_vec_o;

  // ----------------------------------------------------------------
  // Fault history
  // ----------------------------------------------------------------
  logic [32:0] new_set;
  logic [7:0]  new_code;
  logic [2:0]  hist_wp_q;
  logic [2:0]  hist_cnt_q;
  logic        hist_we;
  logic [2:0]  hist_k;
  logic [7:0]  hist_rdata;

  assign new_set  = fault_d & ~fault_vec_o;
  assign new_code = first_code(new_set);
  assign hist_we  = (new_code != 8'h00);

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      hist_wp_q  <= 3'h0;
      hist_cnt_q <= 3'h0;
    end
    else if (hist_we)
    begin
      hist_wp_q <= (hist_wp_q == 3'd5) ? 3'h0 : hist_wp_q + 3'h1;
      if (hist_cnt_q != 3'd6)
      begin
        hist_cnt_q <= hist_cnt_q + 3'h1;
      end
    end
  end

  assign hist_k = 3'(bus_req_i.addr[7:2] - 6'(`SFC_OFS_HIST0 >> 2));

  sfc_hist_mem sfc_hist_mem_inst (
    .sys_clk_i (sys_clk_i),
    .we_i      (hist_we),
    .waddr_i   (hist_wp_q),
    .wdata_i   (new_code),
    .raddr_i   (hist_slot(hist_wp_q, hist_k)),
    .rdata_o   (hist_rdata)
  );

  // ----------------------------------------------------------------
  // Interrupt status, clear and enable
  // ----------------------------------------------------------------
  logic [1:0] irq_stat_q;
  logic [1:0] irq_en_q;
  logic [1:0] irq_evt;

  assign irq_evt[`SFC_IRQ_SET_BIT] = |new_set;
  assign irq_evt[`SFC_IRQ_CLR_BIT] = |(fault_vec_o & ~fault_d);

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      irq_stat_q <= 2'h0;
    end
    else
    begin
      irq_stat_q <= irq_evt | (irq_stat_q & ~(wr_irq_clr ? bus_req_i.wdata[1:0] : 2'h0));
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      irq_en_q <= `SFC_IRQ_EN_RST;
    end
    else if (wr_irq_en)
    begin
      irq_en_q <= bus_req_i.wdata[1:0];
    end
  end

  assign irq_o = |(irq_stat_q & irq_en_q);

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [31:0] rd_reg_q;
  logic        rd_hist_q;
  logic        hist_in_range;

  assign hist_in_range = (bus_req_i.addr >= `SFC_OFS_HIST0) && (bus_req_i.addr <= `SFC_OFS_HIST5)
                         && (bus_req_i.addr[1:0] == 2'h0) && (hist_k < hist_cnt_q);

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      rd_reg_q  <= 32'h0000_0000;
      rd_hist_q <= 1'b0;
    end
    else
    begin
      rd_hist_q <= bus_req_i.rd && hist_in_range;
      rd_reg_q  <= 32'h0000_0000;
      if (bus_req_i.rd)
      begin
        case (bus_req_i.addr)
          `SFC_OFS_FAULT_LO: rd_reg_q <= fault_vec_o[31:0];
          `SFC_OFS_FAULT_HI: rd_reg_q <= {31'h0000_0000, fault_vec_o[32]};
          `SFC_OFS_SPF:      rd_reg_q <= {16'h0000, spf_q};
          `SFC_OFS_IRQ_STAT: rd_reg_q <= {30'h0000_0000, irq_stat_q};
          `SFC_OFS_IRQ_EN:   rd_reg_q <= {30'h0000_0000, irq_en_q};
          `SFC_OFS_FW_STATE: rd_reg_q <= {30'h0000_0000, fw_state_q};
          `SFC_OFS_HIST_CNT: rd_reg_q <= {29'h0000_0000, hist_cnt_q};
          default:           rd_reg_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign bus_rdata_o = rd_hist_q ? {24'h00_0000, hist_rdata} : rd_reg_q;

endmodule // sfc_fault_mgr

// ### test/sfc_fault_mgr_checker.sv
// Assertion checker for the fault clear manager
`timescale 1ns/100ps
`include "sfc_regs.svh"
module sfc_fault_mgr_checker (
  input wire logic                sys_clk_i,
  input wire logic                rst_i,
  input wire logic                restart_i,
  input wire logic [32:0]         fault_det_i,
  input wire sfc_pkg::sfc_recov_t recov_i,
  input wire logic                alarm_reset_input_i,
  input wire logic                emergency_stop_input_i,
  input wire logic [32:0]         fault_vec_o,
  input wire logic                fault_any_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  a_det_sets_latch: assert property (
    fault_det_i != 33'h0 |=> (fault_vec_o & $past(fault_det_i)) == $past(fault_det_i))
    else $error("Detected fault not latched");
  a_any_is_or: assert property (fault_any_o == (|fault_vec_o))
    else $error("Summary flag wrong");
  a_restart_clears: assert property (
    restart_i && fault_det_i == 33'h0 |=> (fault_vec_o & `SFC_RESTART_MASK) == 33'h0)
    else $error("Restart left a fault set");
  a_motor_holds: assert property (fault_vec_o[3] && !restart_i |=> fault_vec_o[3])
    else $error("Motor fault cleared without restart");
  a_rsvd_holds: assert property ((fault_vec_o & `SFC_RSVD_MASK) != 33'h0
    |=> (fault_vec_o & $past(fault_vec_o) & `SFC_RSVD_MASK) == ($past(fault_vec_o) & `SFC_RSVD_MASK))
    else $error("Reserved fault cleared");
  a_uv_auto: assert property (
    fault_vec_o[2] && recov_i.voltage_ok && !fault_det_i[2] |=> !fault_vec_o[2])
    else $error("Undervoltage not cleared");
  a_estop_auto: assert property (
    !emergency_stop_input_i [*3] ##0 fault_vec_o[12] && !fault_det_i[12] |=> !fault_vec_o[12])
    else $error("Stop fault not cleared");
  a_servo_off: assert property (
    fault_vec_o[13] && recov_i.servo_off && !fault_det_i[13] |=> !fault_vec_o[13])
    else $error("Limit fault not cleared");
  a_enc_out_hold: assert property (
    !alarm_reset_input_i [*3] ##0 fault_vec_o[17] |=> fault_vec_o[17])
    else $error("Encoder output fault cleared early");
  a_comm_auto: assert property (
    fault_vec_o[18] && recov_i.comm_ok && !fault_det_i[18] |=> !fault_vec_o[18])
    else $error("Serial fault not cleared");
  a_phase_auto: assert property (
    fault_vec_o[21] && recov_i.phase_ok && !fault_det_i[21] |=> !fault_vec_o[21])
    else $error("Phase fault not cleared");
  a_temp_auto: assert property (
    fault_vec_o[31] && recov_i.temp_ok && !fault_det_i[31] |=> !fault_vec_o[31])
    else $error("Temperature warning not cleared");
  a_fw_holds: assert property (fault_vec_o[32] && !restart_i |=> fault_vec_o[32])
    else $error("Firmware alarm cleared without restart");
endmodule // sfc_fault_mgr_checker

bind sfc_fault_mgr sfc_fault_mgr_checker sfc_fault_mgr_checker_inst (.sys_clk_i, .rst_i, .restart_i,
  .fault_det_i, .recov_i, .alarm_reset_input_i, .emergency_stop_input_i, .fault_vec_o, .fault_any_o);

// ### test/sfc_drive_model.sv
// Model of the drive's fault detectors and condition monitors
`timescale 1ns/100ps
module sfc_drive_model (
  input  wire logic           sys_clk_i,
  input  wire logic           rst_i,
  input  wire logic [32:0]    trip_i,
  input  wire logic           heal_i,
  input  wire logic           servo_off_i,
  input  wire logic           autotune_i,
  output logic      [32:0]    fault_det_o,
  output sfc_pkg::sfc_recov_t recov_o
);
  logic [3:0] bad_q;

  // ----------------------------------------------------------------
  // Detectors pulse one cycle after a trip
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    fault_det_o <= rst_i ? 33'h0 : trip_i;
  end

  // ----------------------------------------------------------------
  // Monitored conditions stay bad until healed
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || heal_i)
      bad_q <= 4'h0;
    else
      bad_q <= bad_q | {trip_i[2], trip_i[18], trip_i[21], trip_i[31]};
  end

  assign recov_o = {~bad_q, servo_off_i, autotune_i};
endmodule // sfc_drive_model

// ### test/sfc_fault_mgr_test.sv
// Self-checking testbench of the fault clear manager
`timescale 1ns/100ps
`include "sfc_regs.svh"
module sfc_fault_mgr_test;
  logic                  sys_clk_i = 1'b0;
  logic                  rst_i     = 1'b1;
  logic                  restart_i = 1'b0;
  logic                  alarm     = 1'b0;
  logic                  estop     = 1'b0;
  logic                  conn      = 1'b1;
  logic                  heal      = 1'b0;
  logic                  servo_off = 1'b0;
  logic                  autotune  = 1'b0;
  logic [32:0]           trip      = 33'h0;
  sfc_pkg::sfc_bus_req_t bus_req   = '0;
  logic [32:0]           fault_det;
  logic [32:0]           fault_vec;
  sfc_pkg::sfc_recov_t   recov;
  logic [31:0]           rdata;
  logic                  fault_any;
  logic                  irq;
  logic [15:0]           seed      = 16'h0001;
  int                    mismatches = 0;
  int                    num_checks = 0;

  initial forever #4 sys_clk_i = ~sys_clk_i;

  sfc_drive_model sfc_drive_model_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .trip_i(trip), .heal_i(heal),
    .servo_off_i(servo_off), .autotune_i(autotune), .fault_det_o(fault_det), .recov_o(recov));
  sfc_fault_mgr sfc_fault_mgr_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .restart_i(restart_i),
    .fault_det_i(fault_det), .recov_i(recov), .alarm_reset_input_i(alarm), .emergency_stop_input_i(estop),
    .io_signal_connector_present_i(conn), .bus_req_i(bus_req), .bus_rdata_o(rdata), .fault_vec_o(fault_vec),
    .fault_any_o(fault_any), .irq_o(irq));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic clears(input int i, input int a);
    logic [32:0] m;
    case (a)
      0: m = `SFC_ALARM_RESET_INPUT_MASK;
      1: m = `SFC_RESTART_MASK;
      2: m = `SFC_SERVOFF_MASK;
      3: m = 33'h0_8024_0004;
      4: m = 33'h0_0000_1000;
      default: m = 33'h0_0000_0800;
    endcase
    return m[i];
  endfunction

  task automatic check(input string name, input logic [32:0] exp, input logic [32:0] got);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk_i);
    bus_req <= '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk_i);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk_i);
    bus_req <= '0;
    #1 check("read data", {1'b0, exp}, {1'b0, rdata});
  endtask

  task automatic reset_dut;
    @(posedge sys_clk_i);
    rst_i <= 1'b1;
    estop <= 1'b0;
    cyc(3);
    rst_i <= 1'b0;
    cyc(2);
  endtask

  task automatic fire(input int i);
    @(posedge sys_clk_i);
    if (i == 12)
      estop <= 1'b1;
    else
      trip <= 33'h1 << i;
    @(posedge sys_clk_i);
    trip <= 33'h0;
    cyc(4);
    #1 check("fault latch", 33'h1, {32'h0, fault_vec[i]});
    check("fault summary", 33'h1, {32'h0, fault_any});
  endtask

  task automatic act(input int a);
    @(posedge sys_clk_i);
    case (a)
      0: alarm <= 1'b1;
      1: restart_i <= 1'b1;
      2: servo_off <= 1'b1;
      3: heal <= 1'b1;
      4: estop <= 1'b0;
      default: conn <= 1'b0;
    endcase
    @(posedge sys_clk_i);
    {alarm, restart_i, servo_off, heal, conn} <= 5'b00001;
    if (a == 5)
    begin
      cyc(4);
      autotune <= 1'b1;
      @(posedge sys_clk_i);
      autotune <= 1'b0;
    end
    cyc(6);
    #1;
  endtask

  task automatic complete_run;
    $display("Checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    cyc(50000);
    mismatches++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    cyc(12);
    rst_i <= 1'b0;
    for (int i = 0; i < 33; i++)
      for (int a = 0; a < 6; a++)
      begin
        reset_dut();
        fire(i);
        if (a == 0)
        begin
          rd(`SFC_OFS_HIST_CNT, 32'h1);
          rd(`SFC_OFS_HIST0, 32'(i + 1));
        end
        act(a);
        check("fault after clear", {32'h0, !clears(i, a)}, {32'h0, fault_vec[i]});
      end
    reset_dut();
    for (int i = 0; i < 7; i++)
      fire(i);
    rd(`SFC_OFS_HIST_CNT, 32'h6);
    for (int k = 0; k < 6; k++)
      rd(8'(`SFC_OFS_HIST0 + 4 * k), 32'(7 - k));
    rd(8'hfc, 32'h0);
    reset_dut();
    wr(`SFC_OFS_IRQ_EN, 32'h3);
    rd(`SFC_OFS_IRQ_EN, 32'h3);
    fire(0);
    rd(`SFC_OFS_IRQ_STAT, 32'h1);
    check("irq raised", 33'h1, {32'h0, irq});
    wr(`SFC_OFS_IRQ_CLR, 32'h1);
    cyc(2);
    #1 check("irq cleared", 33'h0, {32'h0, irq});
    fire(1);
    wr(`SFC_OFS_IRQ_EN, 32'h0);
    cyc(2);
    #1 check("irq masked", 33'h0, {32'h0, irq});
    wr(`SFC_OFS_IRQ_EN, 32'h2);
    act(0);
    check("irq on clear", 33'h1, {32'h0, irq});
    wr(`SFC_OFS_FAULT_LO, 32'hffff_ffff);
    rd(`SFC_OFS_FAULT_LO, 32'h0);
    reset_dut();
    fire(32);
    wr(`SFC_OFS_SPF, 32'd28);
    wr(`SFC_OFS_SPF, 32'd30);
    rd(`SFC_OFS_FW_STATE, 32'h1);
    act(1);
    check("fw alarm kept", 33'h1, {32'h0, fault_vec[32]});
    wr(`SFC_OFS_SPF, 32'd30);
    wr(`SFC_OFS_SPF, 32'd28);
    rd(`SFC_OFS_FW_STATE, 32'h2);
    act(1);
    check("fw alarm cleared", 33'h0, {32'h0, fault_vec[32]});
    repeat (16)
    begin
      seed = lfsr(seed);
      wr(`SFC_OFS_SPF, {seed, seed});
      rd(`SFC_OFS_SPF, {16'h0, seed});
    end
    complete_run();
  end
endmodule // sfc_fault_mgr_test
